// ### dv/key_operator.sv
// front-panel operator model that presses and releases the keys
`timescale 1ns/100ps
module key_operator import scale_menu_pkg::*; (
	// clock
	input wire logic core_clk,
	// key levels, high while pressed
	output keys_t keys
);
	// all keys up at power on
	initial keys = '0;

	// press for hold cycles, then let go and give the panel time to settle;
	// a long hold models a slow hand on enter
	task automatic press(input keys_t k, input int hold);
		keys <= k;
		repeat (hold) @(posedge core_clk);
		keys <= '0;
		repeat (4) @(posedge core_clk);
	endtask
endmodule // key_operator

// ### dv/scale_menu_properties.sv
// concurrent checks of the range and scaling menu at its key and panel ports
`timescale 1ns/100ps
module scale_menu_properties import scale_menu_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// keys and live input
	input wire keys_t keys,
	input wire logic signed [CW-1:0] meas_in,
	// display and indicators
	input wire disp_t panel
);
	// run reading shown and lamp test over
	wire logic is_run = (panel.prompt == run_reading) && !panel.lamp_all;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// a key press taken while a given prompt is shown
	sequence hit(k, prompt_t p);
		$rose(k) && panel.prompt == p;
	endsequence
	// error indication ending
	sequence err_end;
		panel.prompt == error_prompt ##1 panel.prompt != error_prompt;
	endsequence

	lamp_test_a: assert property ($rose(resetn) |-> panel.lamp_all)
		else $error("lamp test not lit after reset");
	prog_open_a: assert property ($rose(keys.enter) && is_run |-> ##2 panel.prompt == programming_prompt)
		else $error("enter in run did not open programming");
	range_step_a: assert property (hit(keys.sel, range_prompt)
		|-> ##2 panel.range == range_t'(2'($past(panel.range, 2)) + 2'h1))
		else $error("range did not step with wrap");
	range_store_a: assert property (hit(keys.enter, range_prompt)
		|-> ##2 panel.store_led && panel.prompt == store_prompt)
		else $error("range enter did not store");
	store_end_a: assert property ($rose(panel.store_led) |-> panel.store_led [*8] ##[1:40] is_run)
		else $error("store indicator not held or store never ended");
	esc_exit_a: assert property ($rose(keys.esc)
		&& panel.prompt inside {[programming_prompt:decimal_point_prompt]} |-> ##2 is_run)
		else $error("escape did not return to run");
	span_error_a: assert property (hit(keys.enter, point_display_coordinate)
		##0 (panel.value > DSP_LIMIT || panel.value < -DSP_LIMIT) |-> ##2 panel.prompt == error_prompt)
		else $error("out of span display value accepted");
	span_accept_a: assert property (hit(keys.enter, point_display_coordinate)
		##0 (panel.point == 5'h00 && panel.value <= DSP_LIMIT && panel.value >= -DSP_LIMIT)
		|-> ##2 panel.prompt == decimal_point_prompt)
		else $error("first display value did not lead to decimal point");
	error_reload_a: assert property (err_end
		|-> panel.prompt == point_display_coordinate && panel.digits == ERR_DIGITS && panel.cursor == 3'h1)
		else $error("error did not reload limit value");
	teach_live_a: assert property (hit(keys.teach, point_input_coordinate)
		|-> ##2 panel.inp_flash && panel.value == meas_in)
		else $error("teach did not show live input");
	coord_led_a: assert property (panel.prompt inside {point_input_coordinate, point_display_coordinate}
		|-> panel.inp_led == (panel.prompt == point_input_coordinate) && panel.dsp_led != panel.inp_led)
		else $error("coordinate indicator wrong");
	dp_move_a: assert property (hit(keys.sel, decimal_point_prompt) |-> ##2 panel.dp_flash
		&& panel.dp_pos == ($past(panel.dp_pos, 2) == DP_NONE ? 3'h0 : $past(panel.dp_pos, 2) + 3'h1))
		else $error("decimal point did not move right");
	input_first_a: assert property (hit(keys.enter, point_input_coordinate)
		|-> ##2 panel.prompt == point_display_coordinate)
		else $error("input coordinate not followed by display coordinate");
endmodule // scale_menu_properties

bind scale_menu scale_menu_properties u_scale_menu_properties (.core_clk(core_clk), .resetn(resetn),
	.keys(keys), .meas_in(meas_in), .panel(panel));

// ### dv/test_scale_menu.sv
// self-checking bench for the range and scaling menu
`timescale 1ns/100ps
module test_scale_menu import scale_menu_pkg::*;;
	localparam int HOLD_N = 40;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic signed [CW-1:0] meas_in = '0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic [31:0] rd;
	keys_t keys;
	disp_t panel;
	logic signed [31:0] run_value;
	wire logic hready;
	logic [31:0] hrdata;
	logic hresp;
	int failures = 0;
	int checked = 0;
	int cycles = 0;

	// 250 MHz clock
	always #2 core_clk = ~core_clk;

	// short lamp, hold and error counts keep the run brief
	scale_menu #(.LAMP_CYCLES(20), .HOLD_CYCLES(HOLD_N), .ERR_CYCLES(10)) u_scale_menu (.core_clk(core_clk),
		.resetn(resetn), .keys(keys), .meas_in(meas_in), .panel(panel), .run_value(run_value), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp));
	key_operator u_key_operator (.core_clk(core_clk), .keys(keys));

	task automatic print_verdict();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// hang guard, far above what the tests need
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one single transfer; entered just after a rising edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge core_clk); while (hready !== 1'b1 && cycles < 20000);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hready !== 1'b1 && cycles < 20000);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	// e enter, s select, i increment, t teach, anything else escape
	task automatic nav(input string s);
		keys_t k;
		for (int i = 0; i < s.len(); i++) begin
			k = '0;
			case (s[i])
				"e": k.enter = 1'b1;
				"s": k.sel = 1'b1;
				"i": k.incr = 1'b1;
				"t": k.teach = 1'b1;
				default: k.esc = 1'b1;
			endcase
			u_key_operator.press(k, 1);
		end
	endtask

	// poll the state field until run, bounded
	task automatic wait_run();
		int n;
		n = 0;
		bus(A_STATUS, 1'b0, 32'h0);
		while (rd[3:0] !== 4'(ST_RUN) && n < 200) begin
			bus(A_STATUS, 1'b0, 32'h0);
			n++;
		end
		chk({28'h0, rd[3:0]}, {28'h0, 4'(ST_RUN)});
	endtask

	task automatic show(input prompt_t p);
		chk(32'(panel.prompt), 32'(p));
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk({31'h0, panel.lamp_all}, 32'h1);
		wait_run();
		chk({31'h0, panel.lamp_all}, 32'h0);
		bus(A_CFG, 1'b0, 32'h0);
		chk(rd, {19'h0, RST_NPTS, DP_NONE, RST_RANGE, RST_RANGE, 1'b0});
		bus(8'h10, 1'b0, 32'h0);
		chk(rd, 32'h0);
		$display("test reset finished");
		// range: one select by software, the rest by hand, wrapping twice
		nav("ese");
		show(range_prompt);
		chk(32'(panel.range), 32'(RST_RANGE));
		bus(A_KEYS, 1'b1, 32'h0000_0008);
		repeat (4) @(posedge core_clk);
		chk(32'(panel.range), 32'(RANGE_15MV));
		for (int i = 1; i < 6; i++) begin
			nav("s");
			chk(32'(panel.range), i % 4);
		end
		nav("e");
		chk({31'h0, panel.store_led}, 32'h1);
		wait_run();
		bus(A_CFG, 1'b0, 32'h0);
		chk(32'(rd[4:3]), 32'(RANGE_30MV));
		$display("test range finished");
		// escape after a shown but unconfirmed range
		nav("ese");
		chk(32'(panel.range), 32'(RANGE_30MV));
		nav("sx");
		wait_run();
		bus(A_CFG, 1'b0, 32'h0);
		chk(32'(rd[4:3]), 32'(RANGE_30MV));
		$display("test escape finished");
		// scaling: menus, sign, span error, decimal point, teach
		nav("ess");
		show(display_module_prompt);
		nav("e");
		for (int i = 0; i < 4; i++) begin
			chk(32'(panel.prompt), 32'(scaling_menu_prompt) + i);
			nav("s");
		end
		show(scaling_menu_prompt);
		nav("e");
		show(point_input_coordinate);
		chk({31'h0, panel.edit}, 32'h1);
		chk({31'h0, panel.inp_led}, 32'h1);
		chk(32'(panel.value), 32'(RST_IN_LO));
		nav("i");
		chk({31'h0, panel.minus}, 32'h1);
		nav("ie");
		show(point_display_coordinate);
		chk({31'h0, panel.dsp_led}, 32'h1);
		nav("siiii");
		chk(32'(panel.digits), 32'h0004_0000);
		nav("e");
		show(error_prompt);
		repeat (12) @(posedge core_clk);
		chk(32'(panel.digits), 32'(ERR_DIGITS));
		chk(32'(panel.cursor), 32'h1);
		nav("iiiiiiie");
		show(decimal_point_prompt);
		chk(32'(panel.dp_pos), 32'(DP_NONE));
		nav("ss");
		chk(32'(panel.dp_pos), 32'h1);
		meas_in <= 18'sd5000;
		nav("et");
		chk({31'h0, panel.inp_flash}, 32'h1);
		chk(32'(panel.value), 32'sd5000);
		nav("ee");
		wait_run();
		chk({31'h0, rd[13]}, 32'h0);
		bus(A_CFG, 1'b0, 32'h0);
		chk({24'h0, rd[12:5]}, 32'h0000_0011);
		meas_in <= 18'sd2500;
		repeat (8) @(posedge core_clk);
		chk(run_value, 32'sd6000);
		meas_in <= 18'sd10000;
		repeat (8) @(posedge core_clk);
		chk(run_value, 32'sd18000);
		$display("test scaling finished");
		// long enter at the second display value goes on to point three
		nav("esseeeeee");
		chk(32'(panel.point), 32'h1);
		u_key_operator.press(keys_t'(5'h10), HOLD_N + 4);
		show(point_input_coordinate);
		chk(32'(panel.point), 32'h2);
		nav("x");
		wait_run();
		bus(A_CFG, 1'b0, 32'h0);
		chk({27'h0, rd[12:8]}, 32'h2);
		$display("test hold finished");
		print_verdict();
	end
endmodule // test_scale_menu

// ### rtl/scale_menu.sv
// keypad menu for input range and multi-point display scaling, with AHB-Lite register slave
`timescale 1ns/100ps
module scale_menu import scale_menu_pkg::*; #(
	parameter int LAMP_CYCLES = LAMP_CYC,
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int ERR_CYCLES = ERR_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// front keys as levels and live measured input
	input wire keys_t keys,
	input wire logic signed [CW-1:0] meas_in,
	// display and indicators
	output disp_t panel,
	output logic signed [31:0] run_value,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);
	state_t st_reg, st_next;
	keys_t prev_reg, sw_press_reg, press;
	logic [31:0] cnt_reg;
	logic cnt_clr;
	logic [4:0] idx_reg, idx_next;
	logic teach_reg, teach_next, pend_reg, pend_next;
	logic signed [CW-1:0] win_reg [NPTS_MAX];
	logic signed [CW-1:0] wdsp_reg [NPTS_MAX];
	logic signed [CW-1:0] nv_in_reg [NPTS_MAX];
	logic signed [CW-1:0] nv_dsp_reg [NPTS_MAX];
	range_t wrange_reg, cand_range_reg, nv_range_reg;
	logic [2:0] wdp_reg, cand_dp_reg, nv_dp_reg;
	logic [4:0] wnpts_reg, nv_npts_reg, npts_val, sidx_reg;
	logic store_busy_reg, store_done;
	logic minus_reg;
	logic [DIGITS*4-1:0] dig_reg;
	logic [2:0] cursor_reg;
	logic signed [CW-1:0] edit_val, load_val, wr_in_val;
	logic load_en, err_load, wr_in, wr_dsp, wr_range, wr_dp, wr_npts, start_store, editing;
	logic reverse;
	logic ap_valid_reg, ap_write_reg;
	logic [7:0] ap_addr_reg;

	// binary to sign and bcd digits, double dabble
	function automatic logic [DIGITS*4:0] to_bcd(input logic signed [CW-1:0] v);
		logic [CW-1:0] mag;
		logic [DIGITS*4-1:0] b;
		mag = v[CW-1] ? CW'(-v) : v;
		b = '0;
		for (int i = CW - 1; i >= 0; i--) begin
			for (int d = 0; d < DIGITS; d++) begin
				if (b[d*4 +: 4] >= 4'h5)
					b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
			end
			b = {b[DIGITS*4-2:0], mag[i]};
		end
		return {v[CW-1], b};
	endfunction

	// sign and bcd digits back to binary
	function automatic logic signed [CW-1:0] from_bcd(input logic m, input logic [DIGITS*4-1:0] b);
		logic [CW-1:0] acc;
		acc = '0;
		for (int d = DIGITS - 1; d >= 0; d--)
			acc = CW'(acc * 10 + b[d*4 +: 4]);
		return m ? CW'(-acc) : acc;
	endfunction

	// key press edges, pins and software injected presses alike
	assign press = (keys & ~prev_reg) | sw_press_reg;
	assign edit_val = from_bcd(minus_reg, dig_reg);
	assign editing = (st_reg == ST_ENT_IN && !teach_reg) || (st_reg == ST_ENT_DSP && !pend_reg);
	assign store_done = store_busy_reg && sidx_reg == LAST_PT;
	assign reverse = wdsp_reg[wnpts_reg - 5'd1] < wdsp_reg[0];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			prev_reg <= '0;
		else
			prev_reg <= keys;
	end

	// menu sequencing; escape is checked last so it wins over every step except lamp test, run and store
	always_comb begin
		st_next = st_reg;
		idx_next = idx_reg;
		teach_next = teach_reg;
		pend_next = pend_reg;
		cnt_clr = 1'b0;
		load_en = 1'b0;
		load_val = '0;
		err_load = 1'b0;
		wr_in = 1'b0;
		wr_in_val = edit_val;
		wr_dsp = 1'b0;
		wr_range = 1'b0;
		wr_dp = 1'b0;
		wr_npts = 1'b0;
		npts_val = wnpts_reg;
		start_store = 1'b0;
		case (st_reg)
			ST_LAMP: begin
				if (cnt_reg >= 32'(LAMP_CYCLES - 1)) begin
					st_next = ST_RUN;
					cnt_clr = 1'b1;
				end
			end
			ST_RUN: if (press.enter) st_next = ST_PROG;
			ST_PROG: if (press.sel) st_next = ST_MOD_IN;
			ST_MOD_IN: begin
				if (press.enter)
					st_next = ST_RANGE;
				else if (press.sel)
					st_next = ST_MOD_DISP;
			end
			ST_RANGE: begin
				if (press.enter) begin
					wr_range = 1'b1;
					start_store = 1'b1;
					st_next = ST_STORE;
				end
			end
			ST_MOD_DISP: begin
				if (press.enter)
					st_next = ST_SCALING_MENU_PROMPT;
				else if (press.sel)
					st_next = ST_PROG;
			end
			ST_SCALING_MENU_PROMPT: begin
				if (press.enter) begin
					st_next = ST_ENT_IN;
					idx_next = '0;
					load_en = 1'b1;
					load_val = win_reg[0];
				end else if (press.sel) begin
					st_next = ST_BAL;
				end
			end
			ST_BAL: if (press.sel) st_next = ST_DAMP;
			ST_DAMP: if (press.sel) st_next = ST_ROUND;
			ST_ROUND: if (press.sel) st_next = ST_SCALING_MENU_PROMPT;
			ST_ENT_IN: begin
				if (press.enter) begin
					wr_in = 1'b1;
					wr_in_val = teach_reg ? meas_in : edit_val;
					teach_next = 1'b0;
					st_next = ST_ENT_DSP;
					load_en = 1'b1;
					load_val = wdsp_reg[idx_reg];
				end else if (press.teach) begin
					teach_next = 1'b1;
				end
			end
			ST_ENT_DSP: begin
				if (!pend_reg) begin
					if (press.enter) begin
						cnt_clr = 1'b1;
						if (edit_val > DSP_LIMIT || edit_val < -DSP_LIMIT) begin
							st_next = ST_ERR;
						end else begin
							wr_dsp = 1'b1;
							if (idx_reg == '0)
								st_next = ST_DP;
							else
								pend_next = 1'b1;
						end
					end
				end else if (!keys.enter || cnt_reg >= 32'(HOLD_CYCLES - 1)) begin
					pend_next = 1'b0;
					// short press at point 2 stores; held press past point 2 stores
					if ((idx_reg == 5'd1) == !keys.enter || idx_reg == LAST_PT) begin
						wr_npts = 1'b1;
						npts_val = idx_reg + 5'd1;
						start_store = 1'b1;
						st_next = ST_STORE;
					end else begin
						idx_next = idx_reg + 5'd1;
						st_next = ST_ENT_IN;
						load_en = 1'b1;
						load_val = win_reg[idx_reg + 5'd1];
					end
				end
			end
			ST_ERR: begin
				if (cnt_reg >= 32'(ERR_CYCLES - 1)) begin
					st_next = ST_ENT_DSP;
					err_load = 1'b1;
				end
			end
			ST_DP: begin
				if (press.enter) begin
					wr_dp = 1'b1;
					idx_next = 5'd1;
					st_next = ST_ENT_IN;
					load_en = 1'b1;
					load_val = win_reg[1];
				end
			end
			ST_STORE: if (store_done) st_next = ST_RUN;
			default: st_next = ST_RUN;
		endcase
		if (press.esc && st_reg != ST_LAMP && st_reg != ST_RUN && st_reg != ST_STORE) begin
			st_next = ST_RUN;
			teach_next = 1'b0;
			pend_next = 1'b0;
			wr_in = 1'b0;
			wr_dsp = 1'b0;
			wr_range = 1'b0;
			wr_dp = 1'b0;
			wr_npts = 1'b0;
			start_store = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= ST_LAMP;
			idx_reg <= '0;
			teach_reg <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			idx_reg <= idx_next;
			teach_reg <= teach_next;
			pend_reg <= pend_next;
		end
	end

	// shared timer for lamp test, enter hold and error display
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			cnt_reg <= '0;
		else if (cnt_clr)
			cnt_reg <= '0;
		else if (cnt_reg != '1)
			cnt_reg <= cnt_reg + 32'd1;
	end

	// value entry buffer: cursor 0 is the sign, 1 is the leftmost digit
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			minus_reg <= 1'b0;
			dig_reg <= '0;
			cursor_reg <= '0;
		end else if (load_en) begin
			{minus_reg, dig_reg} <= to_bcd(load_val);
			cursor_reg <= '0;
		end else if (err_load) begin
			minus_reg <= 1'b0;
			dig_reg <= ERR_DIGITS;
			cursor_reg <= 3'd1;
		end else if (editing && !press.esc) begin
			if (press.sel)
				cursor_reg <= (cursor_reg == CURSOR_LAST) ? 3'd0 : cursor_reg + 3'd1;
			else if (press.incr && cursor_reg == '0)
				minus_reg <= !minus_reg;
			else if (press.incr)
				dig_reg[(DIGITS - 32'(cursor_reg)) * 4 +: 4] <=
					(dig_reg[(DIGITS - 32'(cursor_reg)) * 4 +: 4] == 4'h9) ? 4'h0 :
					dig_reg[(DIGITS - 32'(cursor_reg)) * 4 +: 4] + 4'h1;
		end
	end

	// candidate range and decimal point while their steps are open
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cand_range_reg <= RST_RANGE;
			cand_dp_reg <= DP_NONE;
		end else begin
			if (st_reg == ST_MOD_IN && press.enter)
				cand_range_reg <= wrange_reg;
			else if (st_reg == ST_RANGE && press.sel)
				cand_range_reg <= range_t'(cand_range_reg + 2'd1);
			if (st_next == ST_DP && st_reg != ST_DP)
				cand_dp_reg <= wdp_reg;
			else if (st_reg == ST_DP && press.sel)
				cand_dp_reg <= (cand_dp_reg == DP_NONE) ? 3'd0 : cand_dp_reg + 3'd1;
		end
	end

	// working configuration, changed only by a confirming enter
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NPTS_MAX; i++) begin
				win_reg[i] <= (i == 1) ? RST_IN_HI : RST_IN_LO;
				wdsp_reg[i] <= (i == 1) ? RST_DSP_HI : RST_DSP_LO;
			end
			wrange_reg <= RST_RANGE;
			wdp_reg <= DP_NONE;
			wnpts_reg <= RST_NPTS;
		end else begin
			if (wr_in)
				win_reg[idx_reg] <= wr_in_val;
			if (wr_dsp)
				wdsp_reg[idx_reg] <= edit_val;
			if (wr_range)
				wrange_reg <= cand_range_reg;
			if (wr_dp)
				wdp_reg <= cand_dp_reg;
			if (wr_npts)
				wnpts_reg <= npts_val;
		end
	end

	// non-volatile copy, written one point per cycle so the store LED has a real duration
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NPTS_MAX; i++) begin
				nv_in_reg[i] <= (i == 1) ? RST_IN_HI : RST_IN_LO;
				nv_dsp_reg[i] <= (i == 1) ? RST_DSP_HI : RST_DSP_LO;
			end
			nv_range_reg <= RST_RANGE;
			nv_dp_reg <= DP_NONE;
			nv_npts_reg <= RST_NPTS;
			store_busy_reg <= 1'b0;
			sidx_reg <= '0;
		end else if (start_store) begin
			store_busy_reg <= 1'b1;
			sidx_reg <= '0;
		end else if (store_busy_reg) begin
			nv_in_reg[sidx_reg] <= win_reg[sidx_reg];
			nv_dsp_reg[sidx_reg] <= wdsp_reg[sidx_reg];
			sidx_reg <= sidx_reg + 5'd1;
			if (store_done) begin
				store_busy_reg <= 1'b0;
				nv_range_reg <= wrange_reg;
				nv_dp_reg <= wdp_reg;
				nv_npts_reg <= wnpts_reg;
			end
		end
	end

	// run reading: find bracketing segment, then interpolate; the divider is deep but one shot
	always_ff @(posedge core_clk or negedge resetn) begin
		logic [4:0] seg;
		logic asc;
		logic signed [DW-1:0] num, den, q;
		if (!resetn) begin
			run_value <= '0;
		end else begin
			seg = '0;
			asc = win_reg[wnpts_reg - 5'd1] >= win_reg[0];
			for (int i = 1; i < NPTS_MAX - 1; i++) begin
				if (5'(i) < wnpts_reg - 5'd1 && (asc ? meas_in >= win_reg[i] : meas_in <= win_reg[i]))
					seg = 5'(i);
			end
			num = DW'(meas_in - win_reg[seg]) * DW'(wdsp_reg[seg + 5'd1] - wdsp_reg[seg]);
			den = DW'(win_reg[seg + 5'd1] - win_reg[seg]);
			q = (den == '0) ? '0 : num / den;
			run_value <= 32'(DW'(wdsp_reg[seg]) + q);
		end
	end

	// panel contents, registered
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			panel <= '0;
			panel.prompt <= lamp_test_prompt;
			panel.lamp_all <= 1'b1;
		end else begin
			panel.lamp_all <= st_reg == ST_LAMP;
			panel.edit <= editing;
			panel.minus <= minus_reg;
			panel.digits <= dig_reg;
			panel.cursor <= cursor_reg;
			panel.point <= idx_reg;
			panel.range <= (st_reg == ST_RANGE) ? cand_range_reg : wrange_reg;
			panel.dp_pos <= (st_reg == ST_DP) ? cand_dp_reg : wdp_reg;
			panel.dp_flash <= st_reg == ST_DP;
			panel.inp_led <= st_reg == ST_ENT_IN;
			panel.inp_flash <= st_reg == ST_ENT_IN && teach_reg;
			panel.dsp_led <= st_reg == ST_ENT_DSP || st_reg == ST_ERR;
			panel.store_led <= store_busy_reg;
			panel.value <= (st_reg == ST_RUN) ? CW'(run_value) : (teach_reg ? meas_in : edit_val);
			panel.prompt <= prompt_t'(st_reg);
		end
	end

	// bus slave: zero wait states, read data captured in the address phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge core_clk or negedge resetn) begin
		status_t s;
		cfg_t c;
		if (!resetn) begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_addr_reg <= '0;
			hrdata <= '0;
			sw_press_reg <= '0;
		end else begin
			s = '0;
			s.store_busy = store_busy_reg;
			s.reverse = reverse;
			s.teach = teach_reg;
			s.hold_pend = pend_reg;
			s.point = idx_reg;
			s.state = st_reg;
			c = '0;
			c.nv_npts = nv_npts_reg;
			c.nv_dp = nv_dp_reg;
			c.nv_range = nv_range_reg;
			c.work_range = wrange_reg;
			sw_press_reg <= (ap_valid_reg && ap_write_reg && ap_addr_reg == A_KEYS) ?
				keys_t'(hwdata[$bits(keys_t)-1:0]) : '0;
			if (hready) begin
				ap_valid_reg <= hsel && htrans == HTRANS_NONSEQ;
				ap_write_reg <= hwrite;
				ap_addr_reg <= haddr[7:0];
				if (hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
					case (haddr[7:0])
						A_STATUS: hrdata <= s;
						A_RUN: hrdata <= run_value;
						A_CFG: hrdata <= c;
						default: hrdata <= '0;
					endcase
				end
			end
		end
	end
endmodule // scale_menu

// ### rtl/scale_menu_pkg.sv
// shared constants, types and register map of the range and scaling menu
package scale_menu_pkg;
	// clock and timing figures
	localparam int CLK_KHZ = 250_000;
	localparam int LAMP_MS = 2000;
	localparam int HOLD_MS = 3000;
	localparam int ERR_MS = 1000;
	localparam int LAMP_CYC = LAMP_MS * CLK_KHZ;
	localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
	localparam int ERR_CYC = ERR_MS * CLK_KHZ;
	// scaling geometry
	localparam int NPTS_MAX = 30;
	localparam int NPTS_MIN = 2;
	localparam int DIGITS = 5;
	localparam int CW = 18;
	localparam int DW = 40;
	localparam logic signed [CW-1:0] DSP_LIMIT = 18'sd32000;
	localparam logic [DIGITS*4-1:0] ERR_DIGITS = 20'h3_2000;
	localparam logic [2:0] DP_NONE = 3'(DIGITS - 1);
	localparam logic [2:0] CURSOR_LAST = 3'(DIGITS);
	localparam logic [4:0] LAST_PT = 5'(NPTS_MAX - 1);
	// reset contents of the working and stored configuration
	localparam logic signed [CW-1:0] RST_IN_LO = 18'sd0;
	localparam logic signed [CW-1:0] RST_IN_HI = 18'sd10000;
	localparam logic signed [CW-1:0] RST_DSP_LO = 18'sd0;
	localparam logic signed [CW-1:0] RST_DSP_HI = 18'sd10000;
	localparam logic [4:0] RST_NPTS = 5'(NPTS_MIN);
	// register byte offsets on the bus
	localparam logic [7:0] A_KEYS = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_RUN = 8'h08;
	localparam logic [7:0] A_CFG = 8'h0C;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {RANGE_15MV, RANGE_30MV, RANGE_60MV, RANGE_300MV} range_t;
	localparam range_t RST_RANGE = RANGE_300MV;

	typedef enum logic [3:0] {ST_LAMP, ST_RUN, ST_PROG, ST_MOD_IN, ST_RANGE, ST_MOD_DISP, ST_SCALING_MENU_PROMPT,
		ST_BAL, ST_DAMP, ST_ROUND, ST_ENT_IN, ST_ENT_DSP, ST_DP, ST_ERR, ST_STORE} state_t;

	// prompt codes follow the state codes one for one, lamp test first
	typedef enum logic [3:0] {lamp_test_prompt, run_reading, programming_prompt, input_module_prompt,
		range_prompt, display_module_prompt, scaling_menu_prompt, balanced_filter_prompt,
		damping_filter_prompt, rounding_prompt, point_input_coordinate, point_display_coordinate,
		decimal_point_prompt, error_prompt, store_prompt} prompt_t;

	// front keys, one bit each
	typedef struct packed {
		logic enter;
		logic sel;
		logic incr;
		logic esc;
		logic teach;
	} keys_t;

	// everything the display and indicator LEDs show
	typedef struct packed {
		prompt_t prompt;
		logic signed [CW-1:0] value;
		logic minus;
		logic [DIGITS*4-1:0] digits;
		logic edit;
		logic [2:0] cursor;
		logic [2:0] dp_pos;
		logic dp_flash;
		logic [4:0] point;
		logic inp_led;
		logic inp_flash;
		logic dsp_led;
		logic store_led;
		logic lamp_all;
		range_t range;
	} disp_t;

	typedef struct packed {
		logic [16:0] zero;
		logic store_busy;
		logic reverse;
		logic teach;
		logic hold_pend;
		logic [1:0] zero2;
		logic [4:0] point;
		state_t state;
	} status_t;

	typedef struct packed {
		logic [18:0] zero;
		logic [4:0] nv_npts;
		logic [2:0] nv_dp;
		range_t nv_range;
		range_t work_range;
		logic zero2;
	} cfg_t;
endpackage
